// *** include/pse_remap_pkg.sv ***
// Constants, register map and types for the class demotion and port remap block.
package pse_remap_pkg;

  // Bus addresses.
  localparam logic [6:0] GLOBAL_ADDR   = 7'h7F;
  localparam logic [6:0] DEV_ADDR_DEF  = 7'h20;

  // Register offsets.
  localparam logic [7:0] REG_REQ_CLASS = 8'h0C;
  localparam logic [7:0] REG_SOFT_RST  = 8'h1A;
  localparam logic [7:0] REG_CH_MAP    = 8'h26;
  localparam logic [7:0] REG_ASSIGNED  = 8'h4C;

  // Values after reset.
  localparam logic [7:0] MAP_RESET     = 8'hE4;

  // Sizes.
  localparam int NUM_CH   = 8;
  localparam int NUM_4P   = 4;
  localparam int GROUP_SZ = 4;
  localparam int FIELD_W  = 2;
  localparam int CLS_W    = 4;
  localparam int FING_W   = 3;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // Class values.
  localparam logic [3:0] CLASS_NONE = 4'h0;
  localparam logic [3:0] CLASS_3    = 4'h3;
  localparam logic [3:0] CLASS_4    = 4'h4;
  localparam logic [3:0] CLASS_5    = 4'h5;
  localparam logic [3:0] CLASS_6    = 4'h6;
  localparam logic [3:0] CLASS_7    = 4'h7;
  localparam logic [3:0] CLASS_8    = 4'h8;

  // Classification finger counts.
  localparam logic [2:0] FINGERS_0 = 3'h0;
  localparam logic [2:0] FINGERS_1 = 3'h1;
  localparam logic [2:0] FINGERS_3 = 3'h3;
  localparam logic [2:0] FINGERS_4 = 3'h4;
  localparam logic [2:0] FINGERS_5 = 3'h5;

  typedef enum logic [2:0] {
    ALLOC_15W,
    ALLOC_30W,
    ALLOC_45W,
    ALLOC_60W,
    ALLOC_75W,
    ALLOC_90W
  } alloc_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WR_ACK,
    ST_READ,
    ST_RD_ACK
  } i2c_state_t;

endpackage : pse_remap_pkg

// *** hdl/class_demotion.sv ***
// Assigned class of one 4-pair port from its allocation and requested class.
`timescale 1ns/1ps
`default_nettype none

module class_demotion (
  // Allocation and classification result
  input  wire pse_remap_pkg::alloc_t alloc_i,
  input  wire logic [3:0]            req_class_i,
  input  wire logic                  dual_sig_i,
  // Assigned classes per channel
  output logic [3:0]                 prim_class_o,
  output logic [3:0]                 sec_class_o,
  output logic                       sec_insuff_o
);

  always_comb
  begin
    prim_class_o = req_class_i;
    sec_class_o  = req_class_i;
    sec_insuff_o = 1'b0;
    if (!dual_sig_i)
    begin
      if (req_class_i > pse_remap_pkg::CLASS_3)
      begin
        case (alloc_i)
          pse_remap_pkg::ALLOC_15W: prim_class_o = pse_remap_pkg::CLASS_3;
          pse_remap_pkg::ALLOC_30W: prim_class_o = pse_remap_pkg::CLASS_4;
          pse_remap_pkg::ALLOC_45W:
            if (req_class_i != pse_remap_pkg::CLASS_5)
              prim_class_o = pse_remap_pkg::CLASS_4;
          pse_remap_pkg::ALLOC_60W:
            if (req_class_i > pse_remap_pkg::CLASS_6)
              prim_class_o = pse_remap_pkg::CLASS_6;
          pse_remap_pkg::ALLOC_75W:
            if (req_class_i == pse_remap_pkg::CLASS_8)
              prim_class_o = pse_remap_pkg::CLASS_6;
          default: prim_class_o = req_class_i;
        endcase
      end
      sec_class_o = prim_class_o;
    end
    else if (req_class_i >= pse_remap_pkg::CLASS_3)
    begin
      // Each pairset sees the dual class value as a plain class.
      if (alloc_i == pse_remap_pkg::ALLOC_15W)
      begin
        prim_class_o = pse_remap_pkg::CLASS_3;
        sec_class_o  = pse_remap_pkg::CLASS_NONE;
        sec_insuff_o = 1'b1;
      end
      else if (req_class_i > pse_remap_pkg::CLASS_3)
      begin
        case (alloc_i)
          pse_remap_pkg::ALLOC_30W:
          begin
            prim_class_o = pse_remap_pkg::CLASS_4;
            sec_class_o  = pse_remap_pkg::CLASS_NONE;
            sec_insuff_o = 1'b1;
          end
          pse_remap_pkg::ALLOC_45W:
          begin
            prim_class_o = pse_remap_pkg::CLASS_4;
            sec_class_o  = pse_remap_pkg::CLASS_3;
          end
          pse_remap_pkg::ALLOC_60W:
          begin
            prim_class_o = pse_remap_pkg::CLASS_4;
            sec_class_o  = pse_remap_pkg::CLASS_4;
          end
          pse_remap_pkg::ALLOC_75W: sec_class_o = pse_remap_pkg::CLASS_4;
          default: sec_class_o = req_class_i;
        endcase
      end
    end
  end

endmodule : class_demotion

`default_nettype wire

// *** hdl/pse_class_demotion_port_remap.sv ***
// Class demotion, finger signalling and port remap with its serial register slave.
//
// Overview of operation
// - Grant is shown by fingers: 1 for 15.4W, 3 for 30W, 4 for 60W, 5 for 90W.
// - Demotion lands only on Type boundaries since fingers are the only message.
// - Single signature: 15W gives 3; 30W gives 3 or 4; 45W allows up to 5.
// - Single signature: 60W caps at 6; 75W gives 8 as 6; 90W grants request.
// - Dual at 15W: 3 and insufficient; at 30W 3D 3/3, else 4/insufficient.
// - Dual at 45W/60W never above class 4 per pairset: 3/3, 4/3 or 4/4.
// - Dual X-D is X per pairset; 75W gives 5D as 5D/4; 90W gives 5D/5D.
// - Device also answers writes to the global broadcast address for multi-device loading.
// - Logical ports map to channels only inside their own four-channel group.
// - Map value 00111001 sends port 2 to 3, 3 to 4, 4 to 1.
// - A map write is dropped unless all eight ports of both groups are off.
// - An invalid map value leaves the previous mapping, which reads back.
// - A rejected map write is acknowledged exactly like an accepted one.
// - Two ports naming the same channel make the map value invalid.
// - The soft reset command leaves the map untouched.
// - Power-on or reset pin returns the map to its default.
// - A request above the allocation is shown with fewer fingers.
// - Requested and assigned classes are reported apart and differ on demotion.
`timescale 1ns/1ps
`default_nettype none

module pse_class_demotion_port_remap #(
  parameter logic [6:0] DEV_ADDR = pse_remap_pkg::DEV_ADDR_DEF // Arbitrary value.
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Serial register bus
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // Port state and classification results
  input  wire logic [7:0]  port_off_i,
  input  wire logic [11:0] alloc_i,
  input  wire logic [15:0] req_class_i,
  input  wire logic [3:0]  dual_sig_i,
  // Decisions
  output logic [31:0]      assigned_class_o,
  output logic [15:0]      req_class_o,
  output logic [3:0]       insuff_o,
  output logic [3:0]       demoted_o,
  output logic [23:0]      phys_fingers_o,
  output logic [7:0]       chan_map_o,
  output logic             soft_reset_o
);

  function automatic logic map_valid(input logic [7:0] m);
    logic ok;
    ok = 1'b1;
    for (int a = 0; a < pse_remap_pkg::GROUP_SZ; a++)
      for (int b = a + 1; b < pse_remap_pkg::GROUP_SZ; b++)
        if (m[a*2 +: 2] == m[b*2 +: 2])
          ok = 1'b0;
    return ok;
  endfunction : map_valid

  function automatic logic [2:0] class_fingers(input logic [3:0] c);
    logic [2:0] f;
    f = pse_remap_pkg::FINGERS_5;
    if (c <= pse_remap_pkg::CLASS_3)
      f = pse_remap_pkg::FINGERS_1;
    else if (c == pse_remap_pkg::CLASS_4)
      f = pse_remap_pkg::FINGERS_3;
    else if (c <= pse_remap_pkg::CLASS_6)
      f = pse_remap_pkg::FINGERS_4;
    return f;
  endfunction : class_fingers

  // Pin synchronisers; the first stage feeds only the second.
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_sync & ~scl_prev;
  assign scl_fall  = ~scl_sync & scl_prev;
  assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  pse_remap_pkg::i2c_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       drv_reg, drv_next;
  logic       rw_reg, rw_next;
  logic       first_reg, first_next;
  logic       wr_fire;
  logic [7:0] rd_data;
  logic [7:0] map_reg, map_next;
  logic       soft_reg, soft_next;
  logic [31:0] assigned_reg, assigned_next;
  logic [15:0] req_reg, req_next;
  logic [3:0]  insuff_reg, insuff_next, demoted_reg, demoted_next;
  logic [23:0] phys_reg, phys_next;
  logic [31:0] dem_class;
  logic [3:0]  dem_insuff;

  // Register read-back.
  always_comb
  begin
    rd_data = 8'h00;
    if (ptr_reg == pse_remap_pkg::REG_CH_MAP)
      rd_data = map_reg;
    else if (ptr_reg >= pse_remap_pkg::REG_REQ_CLASS
             && ptr_reg < pse_remap_pkg::REG_REQ_CLASS + 8'h04)
      rd_data = {4'h0, req_reg[ptr_reg[1:0]*4 +: 4]};
    else if (ptr_reg >= pse_remap_pkg::REG_ASSIGNED
             && ptr_reg < pse_remap_pkg::REG_ASSIGNED + 8'h04)
      rd_data = assigned_reg[ptr_reg[1:0]*8 +: 8];
  end

  // Byte-level slave: address, pointer byte, then data bytes.
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    ptr_next   = ptr_reg;
    drv_next   = drv_reg;
    rw_next    = rw_reg;
    first_next = first_reg;
    wr_fire    = 1'b0;
    if (bus_start)
    begin
      state_next = pse_remap_pkg::ST_ADDR;
      cnt_next   = 4'h0;
      drv_next   = 1'b0;
    end
    else if (bus_stop)
    begin
      state_next = pse_remap_pkg::ST_IDLE;
      drv_next   = 1'b0;
    end
    else
    begin
      case (state_reg)
        pse_remap_pkg::ST_ADDR, pse_remap_pkg::ST_WRITE:
          if (scl_rise)
          begin
            sh_next  = {sh_reg[6:0], sda_sync};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == pse_remap_pkg::BIT_LAST)
          begin
            if (state_reg == pse_remap_pkg::ST_WRITE)
            begin
              drv_next   = 1'b1;
              state_next = pse_remap_pkg::ST_WR_ACK;
              if (first_reg)
                ptr_next = sh_reg;
              else
                wr_fire = 1'b1;
            end
            else if (sh_reg[7:1] == DEV_ADDR
                     || (sh_reg[7:1] == pse_remap_pkg::GLOBAL_ADDR && !sh_reg[0]))
            begin
              drv_next   = 1'b1;
              rw_next    = sh_reg[0];
              state_next = pse_remap_pkg::ST_ADDR_ACK;
            end
            else
              state_next = pse_remap_pkg::ST_IDLE;
          end
        pse_remap_pkg::ST_ADDR_ACK, pse_remap_pkg::ST_WR_ACK:
          if (scl_fall)
          begin
            cnt_next = 4'h0;
            if (state_reg == pse_remap_pkg::ST_ADDR_ACK && rw_reg)
            begin
              sh_next    = rd_data;
              drv_next   = ~rd_data[7];
              state_next = pse_remap_pkg::ST_READ;
            end
            else
            begin
              drv_next   = 1'b0;
              first_next = (state_reg == pse_remap_pkg::ST_ADDR_ACK);
              state_next = pse_remap_pkg::ST_WRITE;
            end
          end
        pse_remap_pkg::ST_READ:
          if (scl_fall)
          begin
            if (cnt_reg == 4'h7)
            begin
              drv_next   = 1'b0;
              state_next = pse_remap_pkg::ST_RD_ACK;
            end
            else
            begin
              sh_next  = {sh_reg[6:0], 1'b0};
              drv_next = ~sh_reg[6];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        pse_remap_pkg::ST_RD_ACK:
          if (scl_rise && sda_sync)
            state_next = pse_remap_pkg::ST_IDLE;
          else if (scl_fall)
          begin
            sh_next    = rd_data;
            drv_next   = ~rd_data[7];
            cnt_next   = 4'h0;
            state_next = pse_remap_pkg::ST_READ;
          end
        default: state_next = pse_remap_pkg::ST_IDLE;
      endcase
    end
  end

  // Map register and soft reset command.
  always_comb
  begin
    map_next  = map_reg;
    soft_next = wr_fire && ptr_reg == pse_remap_pkg::REG_SOFT_RST;
    if (wr_fire && ptr_reg == pse_remap_pkg::REG_CH_MAP
        && (&port_off_i) && map_valid(sh_reg))
      map_next = sh_reg;
  end

  for (genvar k = 0; k < pse_remap_pkg::NUM_4P; k++)
  begin : g_dem
    class_demotion u_dem (
      .alloc_i      (pse_remap_pkg::alloc_t'(alloc_i[k*3 +: 3])),
      .req_class_i  (req_class_i[k*4 +: 4]),
      .dual_sig_i   (dual_sig_i[k]),
      .prim_class_o (dem_class[k*8 +: 4]),
      .sec_class_o  (dem_class[k*8+4 +: 4]),
      .sec_insuff_o (dem_insuff[k])
    );
  end

  // Decisions, fingers per logical channel and their routing to channels.
  always_comb
  begin
    logic [23:0] log_f;
    log_f         = 24'h000000;
    assigned_next = dem_class;
    req_next      = req_class_i;
    insuff_next   = dem_insuff;
    demoted_next  = 4'h0;
    phys_next     = 24'h000000;
    for (int k = 0; k < pse_remap_pkg::NUM_4P; k++)
    begin
      demoted_next[k] = dem_class[k*8 +: 4] != req_class_i[k*4 +: 4];
      log_f[k*6 +: 3] = class_fingers(dem_class[k*8 +: 4]);
      log_f[k*6+3 +: 3] = dem_insuff[k] ? pse_remap_pkg::FINGERS_0
                                        : class_fingers(dem_class[k*8+4 +: 4]);
    end
    for (int l = 0; l < pse_remap_pkg::NUM_CH; l++)
      phys_next[((l / 4) * 4 + int'(map_reg[(l % 4)*2 +: 2])) * 3 +: 3] =
        log_f[l*3 +: 3];
    if (soft_reg)
    begin
      assigned_next = 32'h00000000;
      insuff_next   = 4'h0;
      demoted_next  = 4'h0;
      phys_next     = 24'h000000;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg    <= pse_remap_pkg::ST_IDLE;
      cnt_reg      <= 4'h0;
      sh_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      drv_reg      <= 1'b0;
      rw_reg       <= 1'b0;
      first_reg    <= 1'b0;
      map_reg      <= pse_remap_pkg::MAP_RESET;
      soft_reg     <= 1'b0;
      assigned_reg <= 32'h00000000;
      req_reg      <= 16'h0000;
      insuff_reg   <= 4'h0;
      demoted_reg  <= 4'h0;
      phys_reg     <= 24'h000000;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      sh_reg       <= sh_next;
      ptr_reg      <= ptr_next;
      drv_reg      <= drv_next;
      rw_reg       <= rw_next;
      first_reg    <= first_next;
      map_reg      <= map_next;
      soft_reg     <= soft_next;
      assigned_reg <= assigned_next;
      req_reg      <= req_next;
      insuff_reg   <= insuff_next;
      demoted_reg  <= demoted_next;
      phys_reg     <= phys_next;
    end
  end

  assign sda_o            = 1'b0;
  assign sda_oe_n_o       = ~drv_reg;
  assign assigned_class_o = assigned_reg;
  assign req_class_o      = req_reg;
  assign insuff_o         = insuff_reg;
  assign demoted_o        = demoted_reg;
  assign phys_fingers_o   = phys_reg;
  assign chan_map_o       = map_reg;
  assign soft_reset_o     = soft_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_map_valid;
    map_valid(map_reg);
  endproperty
  a_map_valid: assert property (p_map_valid) else $error("map holds duplicate channels");

  property p_map_frozen;
    !(&port_off_i) |=> $stable(map_reg);
  endproperty
  a_map_frozen: assert property (p_map_frozen) else $error("map changed with port on");

  property p_map_accept;
    wr_fire && ptr_reg == pse_remap_pkg::REG_CH_MAP && (&port_off_i) && map_valid(sh_reg)
      |=> map_reg == $past(sh_reg);
  endproperty
  a_map_accept: assert property (p_map_accept) else $error("valid map not taken");

  property p_bad_keep;
    wr_fire && !map_valid(sh_reg) |=> $stable(map_reg);
  endproperty
  a_bad_keep: assert property (p_bad_keep) else $error("invalid map altered mapping");

  property p_ack_hold;
    state_reg == pse_remap_pkg::ST_WR_ACK |-> drv_reg;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("write acknowledge not driven");

  property p_ack_now;
    wr_fire |=> drv_reg && state_reg == pse_remap_pkg::ST_WR_ACK;
  endproperty
  a_ack_now: assert property (p_ack_now) else $error("data write not acknowledged");

  property p_soft_keep;
    soft_reg |=> $past(map_reg, 2) == map_reg;
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset touched map");

  property p_single_15w;
    !soft_reg && !dual_sig_i[0] && alloc_i[2:0] == 3'(pse_remap_pkg::ALLOC_15W)
      && req_class_i[3:0] >= pse_remap_pkg::CLASS_3
      |=> assigned_reg[7:0] == 8'h33 && demoted_reg[0] == ($past(req_class_i[3:0]) != 4'h3);
  endproperty
  a_single_15w: assert property (p_single_15w) else $error("15W single not class 3");

  property p_fingers_90;
    !soft_reg && !dual_sig_i[0] && alloc_i[2:0] == 3'(pse_remap_pkg::ALLOC_90W)
      && req_class_i[3:0] == pse_remap_pkg::CLASS_8 && $stable(map_reg)
      |=> phys_reg[int'($past(map_reg[1:0]))*3 +: 3] == pse_remap_pkg::FINGERS_5;
  endproperty
  a_fingers_90: assert property (p_fingers_90) else $error("class 8 not five fingers");

  property p_pair_cap;
    !soft_reg && dual_sig_i[0] && alloc_i[2:0] <= 3'(pse_remap_pkg::ALLOC_60W)
      |=> assigned_reg[3:0] <= pse_remap_pkg::CLASS_4 && assigned_reg[7:4] <= pse_remap_pkg::CLASS_4;
  endproperty
  a_pair_cap: assert property (p_pair_cap) else $error("pairset above class 4");

  property p_report_split;
    !soft_reg && !dual_sig_i[0] && alloc_i[2:0] == 3'(pse_remap_pkg::ALLOC_60W)
      && req_class_i[3:0] == pse_remap_pkg::CLASS_8
      |=> demoted_reg[0] && req_reg[3:0] == 4'h8 && assigned_reg[3:0] == 4'h6;
  endproperty
  a_report_split: assert property (p_report_split) else $error("demotion not reported");

  c_map_taken: cover property (wr_fire && ptr_reg == pse_remap_pkg::REG_CH_MAP && (&port_off_i));
  c_map_refused: cover property (wr_fire && ptr_reg == pse_remap_pkg::REG_CH_MAP && !(&port_off_i));
  c_demoted: cover property (demoted_reg[0]);
  c_insuff: cover property (insuff_reg[0]);

endmodule : pse_class_demotion_port_remap

`default_nettype wire

// *** sim/i2c_host_model.sv ***
// Behavioural bus master standing in for the host processor.
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
  // Clock
  input  wire logic clk_i,
  // Wire level of the data line
  input  wire logic sda_i,
  // Lines driven, 1 = released to the pull-up
  output logic      scl_o,
  output logic      sda_o
);
  localparam int HALF = 10;

  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Data moves well after the clock fall, so the slave's two-stage sync on both lines sees no false start.
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    tick(HALF);
    scl_o <= 1'b1;
    tick(HALF / 2);
    r = sda_i;
    tick(HALF / 2);
    scl_o <= 1'b0;
    tick(HALF / 2);
  endtask : bit_io

  task automatic start();
    sda_o <= 1'b1;
    tick(HALF);
    scl_o <= 1'b1;
    tick(HALF);
    sda_o <= 1'b0;
    tick(HALF);
    scl_o <= 1'b0;
    tick(HALF / 2);
  endtask : start

  task automatic stop();
    sda_o <= 1'b0;
    tick(HALF);
    scl_o <= 1'b1;
    tick(HALF);
    sda_o <= 1'b1;
    tick(HALF);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte

  // Reads one byte and ends the read with a NACK.
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask : rbyte
endmodule : i2c_host_model
`default_nettype wire

// *** sim/tb_pse_class_demotion_port_remap.sv ***
// Self-checking bench for the class demotion and port remap block.
`timescale 1ns/1ps
`default_nettype none

module tb_pse_class_demotion_port_remap;
  typedef struct packed {
    logic [31:0] ac;
    logic [15:0] rq;
    logic [3:0]  ins;
    logic [3:0]  dem;
    logic [23:0] fg;
  } note_t;

  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        scl_w;
  logic        sda_host;
  logic        sda_dev;
  logic        sda_oe_n;
  wire logic   sda_w;
  logic [7:0]  port_off = 8'hFF;
  logic [11:0] alloc = 12'h000;
  logic [15:0] req = 16'h3333;
  logic [3:0]  dual = 4'h0;
  logic [31:0] ac_w;
  logic [15:0] rq_w;
  logic [3:0]  ins_w;
  logic [3:0]  dem_w;
  logic [23:0] fg_w;
  logic [7:0]  map_w;
  logic        srst_w;
  logic        srst_seen = 1'b0;
  logic [7:0]  exp_map = pse_remap_pkg::MAP_RESET;
  logic [7:0]  rdat;
  logic        ok;
  note_t       q[$];
  note_t       got;
  event        look;
  int          seed = 91;
  int          cyc = 0;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  // Open-drain data line with a pull-up.
  assign sda_w = sda_host & (sda_oe_n | sda_dev);

  i2c_host_model host (
    .clk_i(clk_sys_i),
    .sda_i(sda_w),
    .scl_o(scl_w),
    .sda_o(sda_host)
  );

  pse_class_demotion_port_remap dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_dev), .sda_oe_n_o(sda_oe_n), .port_off_i(port_off), .alloc_i(alloc),
    .req_class_i(req), .dual_sig_i(dual), .assigned_class_o(ac_w), .req_class_o(rq_w),
    .insuff_o(ins_w), .demoted_o(dem_w), .phys_fingers_o(fg_w), .chan_map_o(map_w),
    .soft_reset_o(srst_w)
  );

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, s, e);
    end
  endtask : check

  // Expected {secondary, primary} class; secondary 0 means insufficient power.
  function automatic logic [7:0] exp_cls(input logic [2:0] a, input logic [3:0] c,
                                         input logic d);
    logic [3:0] p;
    logic [3:0] s;
    case (a)
      3'h0: p = 4'h3;
      3'h1: p = (c == 4'h3) ? 4'h3 : 4'h4;
      3'h2: p = (c <= 4'h5 && !d) ? c : ((c == 4'h3) ? 4'h3 : 4'h4);
      3'h3: p = d ? ((c == 4'h3) ? 4'h3 : 4'h4) : ((c <= 4'h6) ? c : 4'h6);
      3'h4: p = (c == 4'h8) ? 4'h6 : c;
      default: p = c;
    endcase
    case (a)
      3'h0: s = 4'h0;
      3'h1: s = (c == 4'h3) ? 4'h3 : 4'h0;
      3'h2: s = 4'h3;
      3'h4: s = (c == 4'h5) ? 4'h4 : c;
      default: s = p;
    endcase
    return d ? {s, p} : {p, p};
  endfunction : exp_cls

  function automatic logic [2:0] fing(input logic [3:0] c);
    return (c == 4'h0) ? 3'h0 : (c <= 4'h3) ? 3'h1 : (c == 4'h4) ? 3'h3 :
           (c <= 4'h6) ? 3'h4 : 3'h5;
  endfunction : fing

  function automatic int phys(input int l);
    return (l & 4) | int'(exp_map[2 * (l % 4) +: 2]);
  endfunction : phys

  task automatic decide();
    note_t       n;
    logic [7:0]  e;
    logic [11:0] na;
    logic [15:0] nc;
    logic [3:0]  nd;
    n = '0;
    for (int k = 0; k < 4; k++)
    begin
      nd[k] = 1'($random(seed));
      na[3 * k +: 3] = 3'($unsigned($random(seed)) % 6);
      nc[4 * k +: 4] = 4'(3 + $unsigned($random(seed)) % (nd[k] ? 3 : 6));
      e = exp_cls(na[3 * k +: 3], nc[4 * k +: 4], nd[k]);
      n.ac[8 * k +: 8] = e;
      n.rq[4 * k +: 4] = nc[4 * k +: 4];
      n.ins[k] = nd[k] && (e[7:4] == 4'h0);
      n.dem[k] = e[3:0] != nc[4 * k +: 4];
      n.fg[3 * phys(2 * k) +: 3] = fing(e[3:0]);
      n.fg[3 * phys(2 * k + 1) +: 3] = fing(e[7:4]);
    end
    @(posedge clk_sys_i);
    alloc <= na;
    req <= nc;
    dual <= nd;
    q.push_back(n);
    repeat (2) @(posedge clk_sys_i);
    #1 ->look;
  endtask : decide

  always @(look)
  begin
    got = q.pop_front();
    check(ac_w, got.ac);
    check(fg_w, got.fg);
    check(ins_w, got.ins);
    check(dem_w, got.dem);
    check(rq_w, got.rq);
  end

  task automatic wr(input logic [6:0] ad, input logic [7:0] rg, input logic [7:0] dt);
    logic a0;
    logic a1;
    logic a2;
    host.start();
    host.wbyte({ad, 1'b0}, a0);
    host.wbyte(rg, a1);
    host.wbyte(dt, a2);
    host.stop();
    ok = a0 & a1 & a2;
  endtask : wr

  task automatic rd_map();
    logic a0;
    host.start();
    host.wbyte({pse_remap_pkg::DEV_ADDR_DEF, 1'b0}, a0);
    host.wbyte(pse_remap_pkg::REG_CH_MAP, a0);
    host.start();
    host.wbyte({pse_remap_pkg::DEV_ADDR_DEF, 1'b1}, a0);
    host.rbyte(rdat);
    host.stop();
  endtask : rd_map

  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (srst_w === 1'b1)
      srst_seen <= 1'b1;
    if (cyc == 60000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check(map_w, pse_remap_pkg::MAP_RESET);
    repeat (30) decide();
    // Register traffic only follows reset, as the block holds no program memory.
    wr(pse_remap_pkg::DEV_ADDR_DEF, pse_remap_pkg::REG_CH_MAP, 8'h39);
    check(ok, 1'b1);
    exp_map = 8'h39;
    check(map_w, 8'h39);
    repeat (20) decide();
    // Two ports naming channel 2 make this value invalid.
    wr(pse_remap_pkg::DEV_ADDR_DEF, pse_remap_pkg::REG_CH_MAP, 8'h35);
    check(ok, 1'b1);
    rd_map();
    check(rdat, 8'h39);
    @(posedge clk_sys_i);
    port_off <= 8'hEF;
    wr(pse_remap_pkg::DEV_ADDR_DEF, pse_remap_pkg::REG_CH_MAP, 8'hE4);
    check(ok, 1'b1);
    check(map_w, 8'h39);
    port_off <= 8'hFF;
    wr(pse_remap_pkg::DEV_ADDR_DEF, pse_remap_pkg::REG_SOFT_RST, 8'h5A);
    check(srst_seen, 1'b1);
    check(map_w, 8'h39);
    wr(pse_remap_pkg::GLOBAL_ADDR, pse_remap_pkg::REG_CH_MAP, 8'h93);
    check(ok, 1'b1);
    exp_map = 8'h93;
    check(map_w, 8'h93);
    repeat (10) decide();
    wr(7'h21, pse_remap_pkg::REG_CH_MAP, 8'hE4);
    check(ok, 1'b0);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check(map_w, pse_remap_pkg::MAP_RESET);
    exp_map = pse_remap_pkg::MAP_RESET;
    repeat (10) decide();
    @(posedge clk_sys_i);
    end_sim();
  end
endmodule : tb_pse_class_demotion_port_remap
`default_nettype wire
